// file: src/cpcs_pkg.sv
// Package for the core sequencer: opcodes, status bit positions, sizes and state layout.
package cpcs_pkg;
  localparam int PC_W       = 9;
  localparam int PROG_DEPTH = 512;
  localparam int INSN_W     = 16;
  localparam int NREGS      = 32;
  localparam int STACK_DEPTH = 3;
  localparam int IO_AW      = 6;
  localparam logic [5:0] STATUS_ADDR  = 6'h3f;
  localparam logic [5:0] BIT_IO_LIMIT = 6'h1f;
  localparam logic [4:0] POINTER_REG  = 5'h1e;
  localparam logic [8:0] RESET_PC     = 9'h000;
  localparam logic [8:0] IRQ_VECTOR   = 9'h001;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int SB_I = 7;
  localparam int SB_T = 6;
  localparam int SB_H = 5;
  localparam int SB_S = 4;
  localparam int SB_V = 3;
  localparam int SB_N = 2;
  localparam int SB_Z = 1;
  localparam int SB_C = 0;
  localparam logic [15:0] NOP_WORD = 16'h0000;

  // Instruction classes decoded from the fetched word.
  typedef enum logic [3:0] {
    CPCS_OP_NOP   = 4'b0000,
    CPCS_OP_ADD   = 4'b0001,
    CPCS_OP_SUB   = 4'b0010,
    CPCS_OP_AND   = 4'b0011,
    CPCS_OP_OR    = 4'b0100,
    CPCS_OP_EOR   = 4'b0101,
    CPCS_OP_MOV   = 4'b0110,
    CPCS_OP_IN    = 4'b0111,
    CPCS_OP_OUT   = 4'b1000,
    CPCS_OP_RJMP  = 4'b1001,
    CPCS_OP_RELATIVE_CALL_OP = 4'b1010,
    CPCS_OP_RET   = 4'b1011,
    CPCS_OP_IRQ_EXIT_OP  = 4'b1100,
    CPCS_OP_IOBIT = 4'b1101,
    CPCS_OP_TBIT  = 4'b1110,
    CPCS_OP_LDP   = 4'b1111
  } cpcs_op_e;

  // I/O port towards the peripheral registers.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cpcs_io_req_s;

  // Sequencer state; the register file is kept apart.
  typedef struct packed {
    logic [8:0]        pc;
    logic [15:0]       insn;
    logic              flush;
    logic [2:0][8:0]   stack;
    logic [7:0]        status;
    logic              io_skip_pending;
  } cpcs_state_s;
endpackage : cpcs_pkg

// file: src/cpcs_core.sv
// Core sequencer: fetch/execute pipeline, register file, ALU, return stack, status.
// Word encoding (this core's own): [15:12] class, [8:4] destination,
// [3:0]+[9] source or bit fields, [11:0] signed offset for relative ops,
// [10:5] port address for port ops, [2:0] bit index for bit ops.
`timescale 1ns/1ps
module cpcs_core
  import cpcs_pkg::*;
#(
  parameter int PROG_WORDS = PROG_DEPTH
)(
  input  wire logic                    clk,
  input  wire logic                    rst,
  output cpcs_pkg::cpcs_io_req_s       io_req,
  input  wire logic [7:0]              io_rdata,
  input  wire logic                    irq_pending,
  output logic                         irq_ack,
  output logic [8:0]                   prog_addr,
  input  wire logic [15:0]             prog_word,
  output logic [7:0]                   status_flags
);
  import cpcs_pkg::*;

  initial
  begin
    if (PROG_WORDS != PROG_DEPTH)
      $error("cpcs_core: program store must be 512 words");
  end

  cpcs_state_s cur;
  cpcs_state_s nxt;
  logic [7:0]  regs [NREGS];

  // Decode fields of the word now executing.
  cpcs_op_e    op;
  logic [4:0]  rd_idx;
  logic [4:0]  rr_idx;
  logic [5:0]  io_a;
  logic [2:0]  bsel;
  logic [8:0]  offs;
  logic [7:0]  opd;
  logic [7:0]  opr;
  logic [7:0]  ptr;
  logic [8:0]  sum9;
  logic [7:0]  res;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic        io_ok;
  logic        take_irq;
  logic [7:0]  next_status;

  assign op     = cpcs_op_e'(cur.insn[15:12]);
  assign rd_idx = cur.insn[8:4];
  assign rr_idx = {cur.insn[9], cur.insn[3:0]};
  assign io_a   = cur.insn[10:5];
  assign bsel   = cur.insn[2:0];
  assign offs   = cur.insn[8:0]; // 12-bit offset wraps within 9-bit space.
  assign opd    = regs[rd_idx];
  assign opr    = regs[rr_idx];
  assign ptr    = regs[POINTER_REG];
  assign io_ok  = (io_a <= BIT_IO_LIMIT);

  // Interrupt taken only with the gate open and no flushed slot.
  assign take_irq = irq_pending && cur.status[SB_I] && !cur.flush;
  assign irq_ack  = take_irq;

  // Port request comes straight from the executing word.
  always_comb
  begin
    io_req       = '0;
    io_req.addr  = io_a;
    if (!cur.flush && !take_irq)
    begin
      unique case (op)
        CPCS_OP_IN:    io_req.rd = 1'b1;
        CPCS_OP_OUT:
        begin
          io_req.wr    = 1'b1;
          io_req.wdata = opd;
        end
        CPCS_OP_IOBIT:
        begin
          io_req.rd = io_ok;
          io_req.wr = io_ok && !cur.insn[11];
          io_req.wdata = cur.insn[3] ? (io_rdata | (8'h01 << bsel))
                                     : (io_rdata & ~(8'h01 << bsel));
        end
        default: ;
      endcase
    end
  end

  // ALU and result selection, one cycle register to register.
  always_comb
  begin
    sum9        = 9'h000;
    res         = opd;
    wr_en       = 1'b0;
    wr_idx      = rd_idx;
    next_status = cur.status;
    if (!cur.flush && !take_irq)
    begin
      unique case (op)
        CPCS_OP_ADD, CPCS_OP_SUB:
        begin
          sum9 = (op == CPCS_OP_ADD) ? ({1'b0, opd} + {1'b0, opr})
                                     : ({1'b0, opd} - {1'b0, opr});
          res  = sum9[7:0];
          wr_en = 1'b1;
          next_status[SB_C] = sum9[8];
          next_status[SB_H] = (op == CPCS_OP_ADD)
            ? ((opd[3] & opr[3]) | (opr[3] & ~res[3]) | (~res[3] & opd[3]))
            : ((~opd[3] & opr[3]) | (opr[3] & res[3]) | (res[3] & ~opd[3]));
          next_status[SB_V] = (op == CPCS_OP_ADD)
            ? ((opd[7] == opr[7]) && (res[7] != opd[7]))
            : ((opd[7] != opr[7]) && (res[7] != opd[7]));
        end
        CPCS_OP_AND, CPCS_OP_OR, CPCS_OP_EOR:
        begin
          res = (op == CPCS_OP_AND) ? (opd & opr)
              : (op == CPCS_OP_OR)  ? (opd | opr) : (opd ^ opr);
          wr_en = 1'b1;
          next_status[SB_V] = 1'b0;
        end
        CPCS_OP_MOV:
        begin
          res   = opr;
          wr_en = 1'b1;
        end
        CPCS_OP_LDP:
        begin
          res    = opd;
          wr_idx = ptr[4:0];
          wr_en  = 1'b1;
        end
        CPCS_OP_IN:
        begin
          res   = (io_a == STATUS_ADDR) ? cur.status : io_rdata;
          wr_en = 1'b1;
        end
        CPCS_OP_OUT:
        begin
          if (io_a == STATUS_ADDR)
            next_status = opd;
        end
        CPCS_OP_TBIT:
        begin
          if (cur.insn[11])
          begin
            res = opd;
            res[bsel] = cur.status[SB_T];
            wr_en = 1'b1;
          end
          else
            next_status[SB_T] = opd[bsel];
        end
        CPCS_OP_IRQ_EXIT_OP: next_status[SB_I] = 1'b1;
        default: ;
      endcase
      if (op inside {CPCS_OP_ADD, CPCS_OP_SUB, CPCS_OP_AND, CPCS_OP_OR, CPCS_OP_EOR})
      begin
        next_status[SB_N] = res[7];
        next_status[SB_Z] = (res == 8'h00);
      end
    end
    if (take_irq)
      next_status[SB_I] = 1'b0;
    next_status[SB_S] = next_status[SB_N] ^ next_status[SB_V];
  end

  // Sequencing: next PC, stack and flush of the prefetched word.
  always_comb
  begin
    nxt        = cur;
    nxt.status = next_status;
    nxt.flush  = 1'b0;
    nxt.insn   = prog_word;
    nxt.pc     = 9'(cur.pc + 9'd1);
    if (take_irq)
    begin
      nxt.stack = {cur.stack[1], cur.stack[0], 9'(cur.pc - 9'd1)};
      nxt.pc    = IRQ_VECTOR;
      nxt.flush = 1'b1;
    end
    else if (!cur.flush)
    begin
      unique case (op)
        CPCS_OP_RJMP, CPCS_OP_RELATIVE_CALL_OP:
        begin
          // Executing word sits at pc-1, so target is its address plus offset plus one.
          nxt.pc    = 9'(cur.pc + offs);
          nxt.flush = 1'b1;
          if (op == CPCS_OP_RELATIVE_CALL_OP)
            nxt.stack = {cur.stack[1], cur.stack[0], cur.pc};
        end
        CPCS_OP_RET, CPCS_OP_IRQ_EXIT_OP:
        begin
          nxt.pc    = cur.stack[0];
          nxt.stack = {cur.stack[2], cur.stack[2], cur.stack[1]};
          nxt.flush = 1'b1;
        end
        CPCS_OP_IOBIT:
        begin
          if (cur.insn[11] && io_ok && (io_rdata[bsel] == cur.insn[3]))
            nxt.flush = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // State register clocked straight from the system clock.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur <= '{pc: RESET_PC, insn: NOP_WORD, flush: 1'b1, stack: '0,
               status: STATUS_RESET, io_skip_pending: 1'b0};
    end
    else
      cur <= nxt;
  end

  // Register file write port, all 32 entries reachable.
  always_ff @(posedge clk)
  begin
    if (wr_en)
      regs[wr_idx] <= res;
  end

  assign prog_addr    = cur.pc;
  assign status_flags = cur.status;

  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    irq_ack |-> $past(1'b1) && cur.status[SB_I]) else $error("irq with gate closed");
  a_irq_clears: assert property (@(posedge clk) disable iff (rst)
    irq_ack |=> !cur.status[SB_I]) else $error("gate not cleared");
  a_sign_bit: assert property (@(posedge clk) disable iff (rst)
    cur.status[SB_S] == (cur.status[SB_N] ^ cur.status[SB_V]))
    else $error("sign bit mismatch");
  a_call_push: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_RELATIVE_CALL_OP) |=>
      cur.stack[0] == $past(cur.pc) && cur.stack[2] == $past(cur.stack[1]))
    else $error("call push wrong");
  a_ret_pop: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_RET) |=>
      cur.pc == $past(cur.stack[0]) && cur.stack[0] == $past(cur.stack[1]))
    else $error("return pop wrong");
  a_rel_target: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_RJMP) |=>
      cur.pc == 9'($past(cur.pc) + $past(offs)) && cur.flush)
    else $error("relative target wrong");
  a_bit_range: assert property (@(posedge clk) disable iff (rst)
    (io_req.wr && op == CPCS_OP_IOBIT) |-> io_a <= BIT_IO_LIMIT)
    else $error("bit op above port limit");
  a_irq_exit_op_sets: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_IRQ_EXIT_OP) |=> cur.status[SB_I])
    else $error("gate not set on return");
  a_pc_step: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_ADD) |=>
      cur.pc == 9'($past(cur.pc) + 9'd1) && !cur.flush)
    else $error("fetch did not advance");

  // Interrupt entry vectors, flushes and saves the preempted word address.
  a_irq_vector: assert property (@(posedge clk) disable iff (rst)
    irq_ack |=> cur.pc == IRQ_VECTOR && cur.flush && cur.stack[0] == 9'($past(cur.pc) - 9'd1))
    else $error("interrupt entry wrong");

  // Interrupt return reloads the PC and moves the deeper levels up.
  a_irq_exit_op_pop: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_IRQ_EXIT_OP) |=>
      cur.pc == $past(cur.stack[0]) && cur.stack[1] == $past(cur.stack[2]))
    else $error("interrupt return pop wrong");

  // A call jumps like a relative jump and pushes level 0 down.
  a_call_target: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_RELATIVE_CALL_OP) |=>
      cur.pc == 9'($past(cur.pc) + $past(offs)) && cur.stack[1] == $past(cur.stack[0]))
    else $error("call target wrong");

  // A bit set or clear always reads the port it writes back.
  a_bit_rmw: assert property (@(posedge clk) disable iff (rst)
    (io_req.wr && op == CPCS_OP_IOBIT) |-> io_req.rd)
    else $error("bit write without read");

  // A discarded slot or an interrupt entry never touches a port.
  a_flush_quiet: assert property (@(posedge clk) disable iff (rst)
    (cur.flush || take_irq) |-> !io_req.rd && !io_req.wr)
    else $error("port access in dead slot");

  // With the gate closed no interrupt is acknowledged.
  a_gate_blocks: assert property (@(posedge clk) disable iff (rst)
    !cur.status[SB_I] |-> !irq_ack)
    else $error("interrupt through closed gate");

  // A two-register add lands in the destination one cycle later.
  a_alu_onecycle: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_ADD) |=> regs[$past(rd_idx)] == $past(res))
    else $error("alu result not written");

  // Bit extract copies the chosen register bit into the holding bit.
  a_extract_t: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_TBIT && !cur.insn[11]) |=>
      cur.status[SB_T] == $past(opd[bsel]))
    else $error("bit extract wrong");

  // A met skip condition discards the prefetched word.
  a_skip_drop: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_IOBIT && cur.insn[11] && io_ok &&
      (io_rdata[bsel] == cur.insn[3])) |=> cur.flush)
    else $error("skip not taken");

  // Pointer store writes the register that the pointer selects.
  a_pointer_write: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_LDP) |=> regs[$past(ptr[4:0])] == $past(opd))
    else $error("pointer store wrong");

  // A status write keeps the flags given, with the sign bit recomputed.
  a_status_out: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_OUT && io_a == STATUS_ADDR) |=>
      cur.status[3:0] == $past(opd[3:0]) && cur.status[7:5] == $past(opd[7:5]))
    else $error("status write wrong");

  // Plain ALU words leave the return stack alone.
  a_stack_hold: assert property (@(posedge clk) disable iff (rst)
    (!cur.flush && !take_irq && op == CPCS_OP_ADD) |=> $stable(cur.stack))
    else $error("stack disturbed");
endmodule // cpcs_core

// file: sim/cpcs_mem_model.sv
// Partner model: asynchronous program store and the peripheral port registers.
`timescale 1ns/1ps
module cpcs_mem_model
  import cpcs_pkg::*;
#(
  parameter logic [5:0] W1C_ADDR = 6'h08
)(
  input  wire logic                   clk,
  input  wire cpcs_pkg::cpcs_io_req_s io_req,
  output logic [7:0]                  io_rdata,
  input  wire logic [8:0]             prog_addr,
  output logic [15:0]                 prog_word
);
  logic [15:0] rom [PROG_DEPTH];
  logic [7:0]  io_mem [64];
  logic [7:0]  noise = 8'h5a;

  // One instruction per 16-bit word, read without a clock.
  assign prog_word = rom[prog_addr];
  // Outside a read the data keeps changing, so a stale byte is never seen.
  assign io_rdata = io_req.rd ? io_mem[io_req.addr] : noise;

  // Writes land at the edge; the flag register clears each bit written as one.
  always @(posedge clk)
  begin
    noise <= noise + 8'h35;
    if (io_req.wr)
    begin
      if (io_req.addr == W1C_ADDR)
        io_mem[io_req.addr] <= io_mem[io_req.addr] & ~io_req.wdata;
      else
        io_mem[io_req.addr] <= io_req.wdata;
    end
  end
endmodule // cpcs_mem_model

// file: sim/test_cpu_core_pc_stack_status.sv
// Testbench: runs small programs on the core and checks ports and peripheral state.
`timescale 1ns/1ps
module test_cpu_core_pc_stack_status;
  import cpcs_pkg::*;
  localparam logic [15:0] SPIN = {CPCS_OP_RJMP, 12'hfff};
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         irq_pending = 1'b0;
  logic         irq_ack;
  logic [7:0]   io_rdata;
  logic [8:0]   prog_addr;
  logic [15:0]  prog_word;
  logic [7:0]   status_flags;
  logic [7:0]   st_isr;
  cpcs_io_req_s io_req;
  int           bad_count = 0;
  int           n_tests = 0;
  int           acks;
  int           hits [64];

  // Free-running system clock.
  always #2.5 clk = ~clk;

  cpcs_core u_cpcs_core (
    .clk(clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
    .irq_pending(irq_pending), .irq_ack(irq_ack), .prog_addr(prog_addr),
    .prog_word(prog_word), .status_flags(status_flags));
  cpcs_mem_model u_cpcs_mem_model (
    .clk(clk), .io_req(io_req), .io_rdata(io_rdata),
    .prog_addr(prog_addr), .prog_word(prog_word));

  // Counts port writes and taken interrupts; notes the flags seen in the handler.
  always @(posedge clk)
  begin
    if (io_req.wr === 1'b1)
    begin
      hits[io_req.addr] <= hits[io_req.addr] + 1;
      if (io_req.addr == 6'h05) st_isr <= status_flags;
    end
    if (irq_ack === 1'b1) acks <= acks + 1;
  end

  // The requester drops its request after the edge that took it.
  always @(negedge clk)
    if (acks != 0) irq_pending <= 1'b0;

  // Cuts a hung run short.
  initial
  begin
    #20000;
    bad_count++;
    end_of_test();
  end

  function automatic logic [15:0] w_io(logic [3:0] c, logic [5:0] p, logic b4);
    return {c, 1'b0, p, b4, 4'h0};
  endfunction
  function automatic logic [15:0] w_rr(logic [3:0] c, logic [4:0] d, logic [4:0] s);
    return {c, 2'b00, s[4], d, s[3:0]};
  endfunction
  function automatic logic [15:0] w_bit(logic sk, logic [5:0] p, logic lv, logic [2:0] b);
    return {CPCS_OP_IOBIT, sk, p, 1'b0, lv, b};
  endfunction
  function automatic logic [7:0] rio(logic [5:0] a);
    return u_cpcs_mem_model.io_mem[a];
  endfunction

  task automatic pw(input int a, input logic [15:0] w);
    u_cpcs_mem_model.rom[a] = w;
  endtask
  task automatic pio(input logic [5:0] a, input logic [7:0] v);
    u_cpcs_mem_model.io_mem[a] = v;
  endtask
  task automatic clr();
    for (int i = 0; i < PROG_DEPTH; i++) pw(i, NOP_WORD);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Resets the core, checks the start state, then lets the program run.
  task automatic start(input int cyc);
    for (int i = 0; i < 64; i++) hits[i] = 0;
    acks = 0;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(prog_addr, RESET_PC, "reset pc");
    chk(status_flags, STATUS_RESET, "reset flags");
    @(negedge clk);
    chk(prog_addr, RESET_PC + 9'd1, "fetch ahead");
    repeat (cyc) @(negedge clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    @(negedge clk);
    // Two-register add, pointer store and bit extract.
    clr();
    pio(6'h02, 8'h80);
    pio(6'h03, 8'h80);
    pio(6'h04, 8'h0c);
    pw(0, w_io(CPCS_OP_IN, 6'h02, 1'b0));
    pw(1, w_io(CPCS_OP_IN, 6'h03, 1'b1));
    pw(2, w_rr(CPCS_OP_ADD, 5'd4, 5'd7));
    pw(3, w_io(CPCS_OP_OUT, 6'h02, 1'b0));
    pw(4, w_io(CPCS_OP_IN, 6'h04, 1'b1));
    pw(5, w_rr(CPCS_OP_MOV, 5'd30, 5'd9));
    pw(6, w_rr(CPCS_OP_LDP, 5'd7, 5'd0));
    pw(7, w_io(CPCS_OP_OUT, 6'h06, 1'b0));
    pw(8, w_rr(CPCS_OP_TBIT, 5'd12, 5'd7));
    pw(9, SPIN);
    start(20);
    chk(rio(6'h02), 16'h0000, "sum");
    chk(rio(6'h06), 16'h0080, "pointer store");
    chk(status_flags, 16'h005b, "flags");
    $display("test alu done");
    // Call chains of full depth and one deeper.
    for (int n = 3; n < 5; n++)
    begin
      clr();
      for (int i = 0; i < n; i++) pw(10 * i, {CPCS_OP_RELATIVE_CALL_OP, 12'd9});
      for (int i = 1; i <= n; i++) pw(10 * i + 1, {CPCS_OP_RET, 12'h000});
      pw(10 * n, {CPCS_OP_RET, 12'h000});
      pw(1, w_io(CPCS_OP_OUT, 6'h05, 1'b0));
      pw(2, SPIN);
      start(40);
      chk(16'(hits[5]), 16'(n == 3), "call chain");
    end
    $display("test stack done");
    // Interrupt held from reset; entry closes the gate and the return reopens it.
    clr();
    pio(6'h04, 8'h80);
    pw(0, {CPCS_OP_RJMP, 12'd3});
    pw(1, w_io(CPCS_OP_OUT, 6'h05, 1'b0));
    pw(2, {CPCS_OP_IRQ_EXIT_OP, 12'h000});
    pw(4, w_io(CPCS_OP_IN, 6'h04, 1'b0));
    pw(5, w_rr(CPCS_OP_MOV, 5'd30, 5'd8));
    pw(6, w_io(CPCS_OP_OUT, 6'h3f, 1'b0));
    pw(7, SPIN);
    irq_pending = 1'b1;
    start(4);
    chk(16'(acks), 16'h0000, "gate closed");
    repeat (20) @(negedge clk);
    chk(16'(acks), 16'h0001, "one entry");
    chk(st_isr[7], 16'h0000, "gate in handler");
    chk(status_flags, 16'h0080, "gate after return");
    chk(16'(prog_addr == 9'd7 || prog_addr == 9'd8), 16'h0001, "resume");
    $display("test irq done");
    // Port bit set, clear and skip, inside and above the low range.
    clr();
    pio(6'h02, 8'h41);
    pio(6'h08, 8'h81);
    pio(6'h22, 8'hff);
    pw(0, w_bit(1'b0, 6'h02, 1'b1, 3'd1));
    pw(1, w_bit(1'b0, 6'h08, 1'b1, 3'd2));
    pw(2, w_bit(1'b0, 6'h22, 1'b0, 3'd0));
    pw(3, w_bit(1'b1, 6'h02, 1'b1, 3'd0));
    pw(4, w_io(CPCS_OP_OUT, 6'h05, 1'b0));
    pw(5, w_bit(1'b1, 6'h02, 1'b0, 3'd0));
    pw(6, w_io(CPCS_OP_OUT, 6'h06, 1'b0));
    pw(7, SPIN);
    start(20);
    chk(rio(6'h02), 16'h0043, "bit set");
    chk(rio(6'h08), 16'h0000, "flag written back");
    chk(16'(hits[6'h22]), 16'h0000, "high port untouched");
    chk(16'(hits[5]), 16'h0000, "skip taken");
    chk(16'(hits[6]), 16'h0001, "skip not taken");
    $display("test bits done");
    end_of_test();
  end
endmodule // test_cpu_core_pc_stack_status
